// [include/smpi_pkg.sv]
// Shared constants for the serial memory pin interface
package smpi_pkg;

   // =====================================================================
   // Array and byte framing
   localparam int DATA_W = 8;
   localparam int ADDR_W = 19;
   localparam int ADDR_BYTES = 3;
   localparam int ARRAY_WORDS = 524288;
   localparam int BIT_CNT_W = 3;
   localparam int BYTE_CNT_W = 3;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
   localparam logic [BYTE_CNT_W-1:0] BYTE_CNT_MAX = 3'h7;
   localparam logic [BYTE_CNT_W-1:0] CMD_BYTE_IDX = 3'h0;
   localparam logic [BYTE_CNT_W-1:0] ADDR_FIRST_IDX = 3'h1;

   // =====================================================================
   // Pin vector layout, reset levels (idle bus: deselected, no hold)
   localparam int PIN_W = 5;
   localparam int PIN_CS = 4;
   localparam int PIN_SCK = 3;
   localparam int PIN_SI = 2;
   localparam int PIN_HOLD = 1;
   localparam int PIN_WP = 0;
   localparam logic [PIN_W-1:0] PIN_RST = 5'h13;
   localparam logic CS_PREV_RST = 1'h1;
   localparam logic SCK_PREV_RST = 1'h0;

   // =====================================================================
   // Timing: serial clock limit against the sampling clock
   localparam int CLK_MHZ = 40;
   localparam int SCK_MAX_MHZ = 50;
   localparam int SCK_MIN_PERIOD_NS = 1000 / SCK_MAX_MHZ;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int SYNC_STAGES = 2;
   localparam int EDGE_LAT_CYC = SYNC_STAGES + 1;

endpackage

// [verilog/smpi_sync.sv]
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module smpi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } smpi_sync_s;

   smpi_sync_s st_r;
   smpi_sync_s st_nxt;

   always_comb begin
      st_nxt.meta = d;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= {RST, RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.sync;

endmodule

// [verilog/smpi_edge.sv]
// Edge finder on a synchronised level, gated by an enable
`timescale 1ns/1ps
module smpi_edge #(
   parameter logic PREV_RST = 1'h0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Level and gate
   input wire logic lvl,
   input wire logic en,
   // Edge pulses
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic prev;
   } smpi_edge_s;

   smpi_edge_s st_r;
   smpi_edge_s st_nxt;

   // Previous level tracks even while gated, so no stale edge on release
   always_comb begin
      st_nxt.prev = lvl;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r.prev <= PREV_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rise = en & lvl & ~st_r.prev;
   assign fall = en & ~lvl & st_r.prev;

endmodule

// [verilog/smpi_pins.sv]
// Pin front end of a serial byte memory, slave on a four-wire bus
`timescale 1ns/1ps
module smpi_pins
   import smpi_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int AW = ADDR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Bus pins
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   input wire logic holdN,
   input wire logic wpN,
   output logic soOut,
   output logic soOe,
   // Received bytes toward command logic
   output logic [DW-1:0] rxByte,
   output logic rxByteValid,
   output logic [DW-1:0] cmdByte,
   output logic cmdValid,
   output logic [AW-1:0] rxAddr,
   output logic [BYTE_CNT_W-1:0] byteIndex,
   // Read data from command logic
   input wire logic readActive,
   input wire logic [DW-1:0] txByte,
   output logic txByteReq,
   // Frame state
   output logic frameEnd,
   output logic partialEnd,
   output logic mode3,
   output logic standby,
   output logic holdActive,
   // Status write gate
   input wire logic statusWrReq,
   output logic statusWrGrant,
   output logic statusWrDeny,
   output logic wpLow
);

   typedef struct packed {
      logic csLow;
      logic mode3;
      logic [BIT_CNT_W-1:0] bitCnt;
      logic seenRise;
      logic [DW-1:0] rxShift;
      logic [BYTE_CNT_W-1:0] byteCnt;
      logic cmdSeen;
      logic [DW-1:0] cmd;
      logic [AW-1:0] addr;
      logic [DW-1:0] rxByte;
      logic rxValid;
      logic cmdValid;
      logic [DW-1:0] txShift;
      logic txOn;
      logic txReq;
      logic soBit;
      logic frameEnd;
      logic partial;
      logic wrGrant;
      logic wrDeny;
   } smpi_pins_s;

   smpi_pins_s st_r;
   smpi_pins_s st_nxt;

   // =====================================================================
   // Pin synchronisers and edge finders
   logic [PIN_W-1:0] pinSync;
   logic csLvl;
   logic sckLvl;
   logic siLvl;
   logic holdHigh;
   logic wpHigh;
   logic csRise;
   logic csFall;
   logic sckRise;
   logic sckFall;
   logic [DW-1:0] rxNext;

   // sampled clock needs a slow serial clock
   smpi_sync #(
      .W(PIN_W),
      .RST(PIN_RST)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({csN, sck, si, holdN, wpN}),
      .q(pinSync)
   );

   assign csLvl = pinSync[PIN_CS];
   assign sckLvl = pinSync[PIN_SCK];
   assign siLvl = pinSync[PIN_SI];
   assign holdHigh = pinSync[PIN_HOLD];
   assign wpHigh = pinSync[PIN_WP];

   smpi_edge #(
      .PREV_RST(CS_PREV_RST)
   ) u_cs_edge (
      .clk(clk),
      .rstn(rstn),
      .lvl(csLvl),
      .en(holdHigh),
      .rise(csRise),
      .fall(csFall)
   );

   // hold and deselect gate clock edges
   smpi_edge #(
      .PREV_RST(SCK_PREV_RST)
   ) u_sck_edge (
      .clk(clk),
      .rstn(rstn),
      .lvl(sckLvl),
      .en(holdHigh & st_r.csLow & ~csRise),
      .rise(sckRise),
      .fall(sckFall)
   );

   assign rxNext = {st_r.rxShift[DW-2:0], siLvl};

   // =====================================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.rxValid = 1'b0;
      st_nxt.cmdValid = 1'b0;
      st_nxt.txReq = 1'b0;
      st_nxt.frameEnd = 1'b0;
      st_nxt.wrGrant = 1'b0;
      st_nxt.wrDeny = 1'b0;
      if (csFall) begin
         st_nxt.csLow = 1'b1;
         st_nxt.mode3 = sckLvl;
         st_nxt.bitCnt = '0;
         st_nxt.seenRise = 1'b0;
         st_nxt.byteCnt = '0;
         st_nxt.cmdSeen = 1'b0;
         st_nxt.addr = '0;
         st_nxt.txOn = 1'b0;
      end else if (csRise) begin
         st_nxt.csLow = 1'b0;
         st_nxt.bitCnt = '0;
         st_nxt.seenRise = 1'b0;
         st_nxt.byteCnt = '0;
         st_nxt.cmdSeen = 1'b0;
         st_nxt.txOn = 1'b0;
         st_nxt.frameEnd = 1'b1;
         // flag ends off a byte boundary
         st_nxt.partial = (st_r.bitCnt != '0);
      end else if (sckRise) begin
         st_nxt.rxShift = rxNext;
         st_nxt.bitCnt = st_r.bitCnt + 1'b1;
         st_nxt.seenRise = 1'b1;
         if (st_r.bitCnt == LAST_BIT) begin
            st_nxt.rxByte = rxNext;
            st_nxt.rxValid = 1'b1;
            if (st_r.byteCnt != BYTE_CNT_MAX) begin
               st_nxt.byteCnt = st_r.byteCnt + 1'b1;
            end
            // first byte is the only command
            if (st_r.byteCnt == CMD_BYTE_IDX && !st_r.cmdSeen) begin
               st_nxt.cmd = rxNext;
               st_nxt.cmdValid = 1'b1;
               st_nxt.cmdSeen = 1'b1;
            end
            if (st_r.byteCnt >= ADDR_FIRST_IDX &&
                st_r.byteCnt <= BYTE_CNT_W'(ADDR_BYTES)) begin
               st_nxt.addr = AW'({st_r.addr, rxNext});
            end
         end
      end else if (sckFall && st_r.seenRise) begin
         // output moves on falling edge only
         if (st_r.bitCnt == '0) begin
            // load read data at byte boundary
            if (readActive) begin
               st_nxt.soBit = txByte[DW-1];
               st_nxt.txShift = {txByte[DW-2:0], 1'b0};
               st_nxt.txOn = 1'b1;
               st_nxt.txReq = 1'b1;
            end else begin
               st_nxt.txOn = 1'b0;
            end
         end else if (st_r.txOn) begin
            st_nxt.soBit = st_r.txShift[DW-1];
            st_nxt.txShift = {st_r.txShift[DW-2:0], 1'b0};
         end
      end
      // status write refused under write protect
      if (statusWrReq && st_r.csLow) begin
         st_nxt.wrGrant = wpHigh;
         st_nxt.wrDeny = ~wpHigh;
      end
   end

   // no timeouts, state holds while clock stops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // Outputs
   // drive only in read data while selected
   assign soOe = st_r.txOn & st_r.csLow & holdHigh;
   assign soOut = st_r.soBit;
   assign rxByte = st_r.rxByte;
   assign rxByteValid = st_r.rxValid;
   assign cmdByte = st_r.cmd;
   assign cmdValid = st_r.cmdValid;
   assign rxAddr = st_r.addr;
   assign byteIndex = st_r.byteCnt;
   assign txByteReq = st_r.txReq;
   assign frameEnd = st_r.frameEnd;
   assign partialEnd = st_r.partial;
   assign mode3 = st_r.mode3;
   assign standby = ~st_r.csLow;
   // suspend indication, only meaningful while selected
   assign holdActive = st_r.csLow & ~holdHigh;
   assign statusWrGrant = st_r.wrGrant;
   assign statusWrDeny = st_r.wrDeny;
   assign wpLow = ~wpHigh;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   chk_standby_quiet:
   assert property (!st_r.csLow |-> !soOe)
      else $error("Output driven while deselected");

   chk_read_only_drive:
   assert property ($rose(st_r.txOn) |-> $past(readActive) && $past(sckFall))
      else $error("Output enabled without read data");

   chk_hold_hiz:
   assert property (!holdHigh |-> !soOe)
      else $error("Output driven during hold");

   chk_so_on_fall:
   assert property ($changed(soOut) |-> $past(sckFall))
      else $error("Output changed off a falling edge");

   chk_wp_refuse:
   assert property (statusWrReq && st_r.csLow && !wpHigh
      |=> statusWrDeny && !statusWrGrant)
      else $error("Status write not refused under protect");

   chk_rx_on_rise:
   assert property ($changed(st_r.rxShift) |-> $past(sckRise))
      else $error("Input sampled off a rising edge");

   chk_byte_frame:
   assert property (rxByteValid |-> $past(st_r.bitCnt) == LAST_BIT
      && st_r.bitCnt == '0)
      else $error("Byte delivered off an eight bit boundary");

   chk_static_hold:
   assert property (!sckRise && !sckFall && !csRise && !csFall
      |=> $stable(st_r.bitCnt) && $stable(st_r.byteCnt))
      else $error("State moved without a pin edge");

   chk_hold_freeze:
   assert property (!holdHigh |=> $stable(st_r.bitCnt) && $stable(st_r.csLow)
      && $stable(st_r.txShift))
      else $error("Transaction moved during hold");

   chk_mode_pick:
   assert property (csFall |=> mode3 == $past(sckLvl))
      else $error("Mode not taken at select fall");

   chk_one_cmd:
   assert property (cmdValid |-> $past(st_r.byteCnt) == CMD_BYTE_IDX
      && st_r.byteCnt == ADDR_FIRST_IDX)
      else $error("Command taken off the first byte");

   chk_cs_clear:
   assert property (csRise |=> st_r.bitCnt == '0 && !st_r.cmdSeen
      && frameEnd && standby)
      else $error("Frame state not cleared at deselect");

   cov_command: cover property (cmdValid);
   cov_mode3: cover property (csFall && sckLvl);
   cov_read: cover property (txByteReq ##1 soOe);
   cov_hold: cover property (holdActive);
   cov_partial: cover property (frameEnd && partialEnd);

endmodule

// [testbench/smpi_host.sv]
// Bus host model driving the serial memory pins
`timescale 1ns/1ps
module smpi_host (
   // Clock
   input wire logic clk,
   // Pins toward the memory
   output logic csN,
   output logic sck,
   output logic si,
   output logic holdN,
   output logic wpN,
   // Serial output from the memory
   input wire logic soOut,
   input wire logic soOe
);
   // Released output line shows a toggling pattern
   wire soLine = soOe ? soOut : ~sck;
   initial begin
      csN = 1'h1;
      sck = 1'h0;
      si = 1'h0;
      holdN = 1'h1;
      wpN = 1'h1;
   end
   task automatic halfWait();
      repeat (4) @(negedge clk);
   endtask
   task automatic start(input logic m3);
      sck = m3;
      halfWait();
      csN = 1'h0;
      halfWait();
   endtask
   task automatic shift(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         sck = 1'h0;
         si = tx[7-i];
         halfWait();
         sck = 1'h1;
         halfWait();
         rx = {rx[6:0], soLine};
      end
   endtask
   task automatic finish(input logic m3);
      sck = m3;
      halfWait();
      csN = 1'h1;
      si = ~si;
      repeat (8) @(negedge clk);
   endtask
   task automatic protect(input logic v);
      wpN = v;
      repeat (4) @(negedge clk);
   endtask
   task automatic hold(input logic v);
      holdN = v;
      repeat (8) @(negedge clk);
   endtask
   // Select and clock toggles during hold
   task automatic disturb();
      sck = ~sck;
      csN = 1'h1;
      halfWait();
      sck = ~sck;
      csN = 1'h0;
      halfWait();
   endtask
endmodule

// [testbench/spi_mram_pin_interface_tb.sv]
// Self-checking bench for the serial memory pin front end
`timescale 1ns/1ps
module spi_mram_pin_interface_tb import smpi_pkg::*;;
   logic clk, rstn, csN, sck, si, holdN, wpN, soOut, soOe;
   logic [7:0] rxByte, cmdByte, txByte;
   logic [18:0] rxAddr;
   logic [2:0] byteIndex;
   logic rxByteValid, cmdValid, readActive, txByteReq, frameEnd;
   logic partialEnd, mode3, standby, holdActive;
   logic statusWrReq, statusWrGrant, statusWrDeny, wpLow;
   int mismatches = 0, nChecks = 0, cyc = 0;
   int nCmd = 0, nRx = 0, nGrant = 0, nDeny = 0, nReq = 0, nEnd = 0;

   smpi_pins u_smpi_pins (.clk(clk), .rstn(rstn), .csN(csN), .sck(sck),
      .si(si), .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe),
      .rxByte(rxByte), .rxByteValid(rxByteValid), .cmdByte(cmdByte),
      .cmdValid(cmdValid), .rxAddr(rxAddr), .byteIndex(byteIndex),
      .readActive(readActive), .txByte(txByte), .txByteReq(txByteReq),
      .frameEnd(frameEnd), .partialEnd(partialEnd), .mode3(mode3),
      .standby(standby), .holdActive(holdActive),
      .statusWrReq(statusWrReq), .statusWrGrant(statusWrGrant),
      .statusWrDeny(statusWrDeny), .wpLow(wpLow));
   smpi_host u_smpi_host (.clk(clk), .csN(csN), .sck(sck), .si(si),
      .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe));

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      nCmd <= nCmd + int'(cmdValid === 1'h1);
      nRx <= nRx + int'(rxByteValid === 1'h1);
      nGrant <= nGrant + int'(statusWrGrant === 1'h1);
      nDeny <= nDeny + int'(statusWrDeny === 1'h1);
      nReq <= nReq + int'(txByteReq === 1'h1);
      nEnd <= nEnd + int'(frameEnd === 1'h1);
      if (cyc == 30000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ====================================================================
   // Read frame with a stalled clock mid-byte
   task automatic t_read(input logic m3);
      logic [7:0] r, tx;
      logic [23:0] a;
      int c0, q0, e0;
      c0 = nCmd;
      q0 = nReq;
      e0 = nEnd;
      a = 24'hfabcde;
      tx = m3 ? 8'h3c : 8'ha5;
      u_smpi_host.start(m3);
      u_smpi_host.shift(8, 8'h03, r);
      u_smpi_host.shift(8, a[23:16], r);
      u_smpi_host.shift(4, a[15:8], r);
      repeat (200) @(negedge clk);
      u_smpi_host.shift(4, {a[11:8], 4'h0}, r);
      u_smpi_host.shift(8, a[7:0], r);
      chk(soOe, 1'h0);
      readActive = 1'h1;
      txByte = tx;
      u_smpi_host.shift(8, 8'h00, r);
      readActive = 1'h0;
      chk(r, tx);
      repeat (4) @(negedge clk);
      chk(byteIndex, 3'h5);
      chk(rxAddr, a[18:0]);
      chk(cmdByte, 8'h03);
      chk(mode3, m3);
      u_smpi_host.finish(m3);
      chk(standby, 1'h1);
      chk(soOe, 1'h0);
      chk(partialEnd, 1'h0);
      chk(nCmd - c0, 1);
      chk(nReq - q0, 1);
      chk(nEnd - e0, 1);
      $display("test read mode %0d done", m3);
   endtask

   // Hold in mid read with select and clock noise
   task automatic t_hold();
      logic [7:0] r1, r2;
      u_smpi_host.start(1'h0);
      u_smpi_host.shift(8, 8'h03, r1);
      for (int i = 0; i < 3; i++) u_smpi_host.shift(8, 8'h00, r1);
      readActive = 1'h1;
      txByte = 8'h96;
      u_smpi_host.shift(4, 8'h00, r1);
      u_smpi_host.hold(1'h0);
      chk(soOe, 1'h0);
      chk(holdActive, 1'h1);
      u_smpi_host.disturb();
      u_smpi_host.hold(1'h1);
      u_smpi_host.shift(4, 8'h00, r2);
      readActive = 1'h0;
      chk({r1[3:0], r2[3:0]}, 8'h96);
      repeat (4) @(negedge clk);
      chk(byteIndex, 3'h5);
      u_smpi_host.finish(1'h0);
      $display("test hold done");
   endtask

   task automatic wrReq();
      statusWrReq = 1'h1;
      @(negedge clk);
      statusWrReq = 1'h0;
      repeat (3) @(negedge clk);
   endtask

   // Status write gate and deselected requests
   task automatic t_wp();
      logic [7:0] r;
      int g, d;
      g = nGrant;
      d = nDeny;
      wrReq();
      chk(nGrant + nDeny - g - d, 0);
      u_smpi_host.start(1'h0);
      u_smpi_host.shift(8, 8'h01, r);
      u_smpi_host.protect(1'h0);
      chk(wpLow, 1'h1);
      wrReq();
      chk(nDeny - d, 1);
      u_smpi_host.protect(1'h1);
      wrReq();
      chk(nGrant - g, 1);
      u_smpi_host.finish(1'h0);
      $display("test protect done");
   endtask

   // Aborted frame, ignored clocks, fresh command
   task automatic t_partial();
      logic [7:0] r;
      int c;
      u_smpi_host.start(1'h0);
      u_smpi_host.shift(4, 8'h50, r);
      u_smpi_host.finish(1'h0);
      chk(partialEnd, 1'h1);
      c = nRx;
      u_smpi_host.shift(8, 8'hff, r);
      u_smpi_host.finish(1'h0);
      chk(nRx - c, 0);
      u_smpi_host.start(1'h0);
      u_smpi_host.shift(8, 8'h06, r);
      repeat (4) @(negedge clk);
      chk(cmdByte, 8'h06);
      chk(rxByte, 8'h06);
      chk(byteIndex, 3'h1);
      u_smpi_host.finish(1'h0);
      chk(partialEnd, 1'h0);
      $display("test partial done");
   endtask

   initial begin
      rstn = 1'h0;
      readActive = 1'h0;
      txByte = 8'h00;
      statusWrReq = 1'h0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      rstn = 1'h1;
      repeat (4) @(negedge clk);
      chk(standby, 1'h1);
      chk(soOe, 1'h0);
      t_read(1'h0);
      t_read(1'h1);
      t_hold();
      t_wp();
      t_partial();
      stop_test();
   end
endmodule
